// ==== rtl/bank_timing_consts.vh ====
// register offsets, field positions and reset values for the bank wait-state timing block
`ifndef BANK_TIMING_CONSTS_VH
`define BANK_TIMING_CONSTS_VH
`define BANK0_READ_TIMING_OFS  16'h1508
`define BANK0_WRITE_TIMING_OFS 16'h150C
`define BANK1_READ_TIMING_OFS  16'h1514
`define BANK1_WRITE_TIMING_OFS 16'h1518
`define ADDR_WAITS_HI          18
`define ADDR_WAITS_LO          16
`define BEAT_WAITS_HI          10
`define BEAT_WAITS_LO          8
`define EXTRA_REC_HI           2
`define EXTRA_REC_LO           0
`define WAITS_RESET            3'h7
`define TIMING_RESET           32'h0007_0707
`define TIMING_WMASK           32'h0007_0707
`define BASE_RECOVERY          4'h1
`endif

// ==== rtl/wait_counter.v ====
// loadable down counter that times one wait or recovery phase
module wait_counter (
  input  wire       mclk_i,
  input  wire       reset_i,
  input  wire       load_i,
  input  wire [3:0] count_i,
  output wire       done_o
);
  reg [3:0] cnt_r;
  reg [3:0] cnt_nxt;

  always @* begin
    cnt_nxt = cnt_r;
    if (load_i) begin
      cnt_nxt = count_i;
    end else if (cnt_r != 4'h0) begin
      cnt_nxt = cnt_r - 4'h1;
    end
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done_o = (cnt_r == 4'h0) & ~load_i;
endmodule // wait_counter

// ==== rtl/bank_wait_state_timing.v ====
// per-bank read/write wait-state timing registers and bus cycle sequencer
// What this block does
// - each bank has its own write timing register, independent of its read timing register.
// - one base recovery cycle always follows the last data beat before the next address phase.
// - read timing bits 2:0, reset 111, add that many extra idle cycles after the last read data.
// - recovery fields are binary, so value n adds exactly n extra recovery cycles.
// - write timing bits 18:16, reset 111, give n wait states from address to first write data.
// - write timing bits 10:8, reset 111, give n wait states between burst write beats.
// - write timing bits 2:0, reset 111, give n extra recovery cycles after the last write data.
// - all wait and recovery counts are whole cycles of the processor clock.
// - read timing bits 18:16, reset 111, give n wait states from address to first read data.
// - read timing bits 10:8, reset 111, give n wait states between burst read beats.
`include "bank_timing_consts.vh"
module bank_wait_state_timing #(
  parameter BEAT_CNT_W = 4
) (
  input  wire                  mclk_i,
  input  wire                  reset_i,
  // register port on the local bus
  input  wire                  reg_wr_i,
  input  wire                  reg_rd_i,
  input  wire [15:0]           reg_addr_i,
  input  wire [31:0]           reg_wdata_i,
  output reg  [31:0]           reg_rdata_o,
  output reg                   reg_ack_o,
  // access requests from the core
  input  wire                  acc_start_i,
  input  wire                  acc_bank_i,
  input  wire                  acc_write_i,
  input  wire [BEAT_CNT_W-1:0] acc_beats_i,
  // cycle status toward memory
  output reg                   mem_addr_phase_o,
  output reg                   mem_data_ready_o,
  output reg                   mem_last_o,
  output reg                   mem_recovery_o,
  output reg                   busy_o
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_WAIT = 3'd2;
  localparam ST_DATA = 3'd3;
  localparam ST_REC  = 3'd4;
  localparam [BEAT_CNT_W-1:0] BEAT_ONE = {{(BEAT_CNT_W-1){1'b0}}, 1'b1};

  wire [31:0]          rd_timing [0:1];
  wire [31:0]          wr_timing [0:1];
  reg [2:0]            state_r;
  reg [2:0]            state_nxt;
  reg [BEAT_CNT_W-1:0] beats_r;
  reg [BEAT_CNT_W-1:0] beats_nxt;
  reg [31:0]           sel_timing_r;
  reg [31:0]           sel_timing_nxt;
  reg                  cnt_load;
  reg [3:0]            cnt_value;
  wire                 cnt_done;
  reg [31:0]           rdata_nxt;
  wire [2:0]           addr_waits;
  wire [2:0]           beat_waits;
  wire [2:0]           extra_rec;

  // reads back the register at an offset; unmapped offsets read zero
  function [31:0] reg_read;
    input [15:0] ofs;
    begin
      if (ofs == `BANK0_READ_TIMING_OFS) begin
        reg_read = rd_timing[0];
      end else if (ofs == `BANK0_WRITE_TIMING_OFS) begin
        reg_read = wr_timing[0];
      end else if (ofs == `BANK1_READ_TIMING_OFS) begin
        reg_read = rd_timing[1];
      end else if (ofs == `BANK1_WRITE_TIMING_OFS) begin
        reg_read = wr_timing[1];
      end else begin
        reg_read = 32'h0000_0000;
      end
    end
  endfunction

  // a load is followed by one counted cycle, so a phase of n cycles loads n-1;
  // a zero field wraps here, which the recovery sum relies on
  function [3:0] wait_load;
    input [2:0] field;
    begin
      wait_load = {1'b0, field} - 4'h1;
    end
  endfunction

  // reserved bits are masked so they always read as zero
  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1) begin : g_bank
      reg [31:0] rd_r;
      reg [31:0] wr_r;
      always @(posedge mclk_i) begin
        if (reset_i) begin
          rd_r <= `TIMING_RESET;
          wr_r <= `TIMING_RESET;
        end else if (reg_wr_i) begin
          if (reg_addr_i == (b ? `BANK1_READ_TIMING_OFS : `BANK0_READ_TIMING_OFS)) begin
            rd_r <= reg_wdata_i & `TIMING_WMASK;
          end
          if (reg_addr_i == (b ? `BANK1_WRITE_TIMING_OFS : `BANK0_WRITE_TIMING_OFS)) begin
            wr_r <= reg_wdata_i & `TIMING_WMASK;
          end
        end
      end
      // each bank keeps its own pair of words, so no word has a second driver
      assign rd_timing[b] = rd_r;
      assign wr_timing[b] = wr_r;
    end
  endgenerate

  assign addr_waits = sel_timing_r[`ADDR_WAITS_HI:`ADDR_WAITS_LO];
  assign beat_waits = sel_timing_r[`BEAT_WAITS_HI:`BEAT_WAITS_LO];
  assign extra_rec  = sel_timing_r[`EXTRA_REC_HI:`EXTRA_REC_LO];

  // without a read strobe the last read word stands
  always @* begin
    rdata_nxt = reg_rd_i ? reg_read(reg_addr_i) : reg_rdata_o;
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 32'h0000_0000;
      reg_ack_o   <= 1'b0;
    end else begin
      reg_rdata_o <= rdata_nxt;
      reg_ack_o   <= reg_rd_i | reg_wr_i;
    end
  end

  wait_counter u_wait (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .load_i  (cnt_load),
    .count_i (cnt_value),
    .done_o  (cnt_done)
  );

  // every phase is a whole number of clock cycles; a field of n gives exactly n
  // wait or extra recovery cycles, with no hidden pipeline cycle
  always @* begin
    state_nxt      = state_r;
    beats_nxt      = beats_r;
    sel_timing_nxt = sel_timing_r;
    cnt_load       = 1'b0;
    cnt_value      = 4'h0;
    case (state_r)
      ST_IDLE: begin
        if (acc_start_i) begin
          // latch the timing word now so mid-access register writes cannot disturb it
          sel_timing_nxt = acc_write_i ? wr_timing[acc_bank_i] : rd_timing[acc_bank_i];
          beats_nxt      = acc_beats_i;
          state_nxt      = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (addr_waits == 3'h0) begin
          // zero waits: first data follows the address phase directly
          state_nxt = ST_DATA;
        end else begin
          cnt_load  = 1'b1;
          cnt_value = wait_load(addr_waits);
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cnt_done) begin
          state_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        if (beats_r <= BEAT_ONE) begin
          // recovery lasts the base cycle plus the binary-coded extra cycles
          cnt_load  = 1'b1;
          cnt_value = wait_load(extra_rec) + `BASE_RECOVERY;
          state_nxt = ST_REC;
        end else if (beat_waits == 3'h0) begin
          // zero waits: the next beat follows at once
          beats_nxt = beats_r - BEAT_ONE;
          state_nxt = ST_DATA;
        end else begin
          cnt_load  = 1'b1;
          cnt_value = wait_load(beat_waits);
          beats_nxt = beats_r - BEAT_ONE;
          state_nxt = ST_WAIT;
        end
      end
      ST_REC: begin
        if (cnt_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      state_r          <= ST_IDLE;
      beats_r          <= {BEAT_CNT_W{1'b0}};
      sel_timing_r     <= 32'h0000_0000;
      mem_addr_phase_o <= 1'b0;
      mem_data_ready_o <= 1'b0;
      mem_last_o       <= 1'b0;
      mem_recovery_o   <= 1'b0;
      busy_o           <= 1'b0;
    end else begin
      state_r          <= state_nxt;
      beats_r          <= beats_nxt;
      sel_timing_r     <= sel_timing_nxt;
      mem_addr_phase_o <= (state_nxt == ST_ADDR);
      mem_data_ready_o <= (state_nxt == ST_DATA);
      // strobes follow the next state, so each stands exactly while state_r shows it
      mem_last_o       <= (state_nxt == ST_DATA) && (beats_nxt <= BEAT_ONE);
      mem_recovery_o   <= (state_nxt == ST_REC);
      busy_o           <= (state_nxt != ST_IDLE);
    end
  end
endmodule // bank_wait_state_timing

// ==== tb/mem_dev.sv ====
// far-side memory model that times the address, data and recovery phases
module mem_dev (
  input  wire logic       mclk_i,
  input  wire logic       addr_i,
  input  wire logic       data_i,
  input  wire logic       rec_i,
  output logic      [7:0] gap_o,
  output logic      [7:0] beat_o,
  output logic      [7:0] rec_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_r = 8'h00;
  logic       first_r = 1'b0;
  // edges since the last event, so a phase reads in whole clocks
  always @(posedge mclk_i) begin
    cnt_r <= cnt_r + 8'h01;
    if (rec_i) rec_o <= rec_o + 8'h01;
    if (addr_i) begin
      cnt_r <= 8'h01;
      first_r <= 1'b1;
      rec_o <= 8'h00;
    end
    if (data_i) begin
      cnt_r <= 8'h01;
      first_r <= 1'b0;
      beat_o <= cnt_r;
      if (first_r) gap_o <= cnt_r;
    end
  end
endmodule // mem_dev

// ==== tb/bank_timing_sva.sv ====
// port checks for the bank wait-state timing block
module bank_timing_sva (
  input wire logic        mclk_i, reset_i, reg_wr_i, reg_rd_i, reg_ack_o, acc_start_i, busy_o,
  input wire logic        mem_addr_phase_o, mem_data_ready_o, mem_last_o, mem_recovery_o,
  input wire logic [31:0] reg_rdata_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  sequence base_rec; mem_recovery_o ##1 !mem_addr_phase_o; endsequence
  sequence next_beat; ##[0:7] mem_data_ready_o; endsequence
  AST_ACK: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o) else $error("no ack");
  AST_RSVD: assert property (reg_ack_o |-> !(reg_rdata_o & 32'hFFF8_F8F8)) else $error("rsvd");
  AST_START: assert property (acc_start_i && !busy_o |=> mem_addr_phase_o && busy_o) else $error("start");
  AST_ONE_ADDR: assert property (mem_addr_phase_o |-> !$past(busy_o)) else $error("addr");
  AST_ADDR_WAIT: assert property (mem_addr_phase_o |=> next_beat) else $error("a wait");
  AST_BEAT_WAIT: assert property (mem_data_ready_o && !mem_last_o |=> next_beat) else $error("d wait");
  AST_LAST: assert property (mem_last_o |-> mem_data_ready_o) else $error("last");
  AST_BASE_REC: assert property (mem_last_o |=> base_rec) else $error("base rec");
  AST_REC_END: assert property (mem_last_o |=> ##[1:8] !busy_o) else $error("rec end");
  AST_REC_QUIET: assert property (mem_recovery_o |-> busy_o && !mem_data_ready_o) else $error("rec");
endmodule // bank_timing_sva
bind bank_wait_state_timing bank_timing_sva chk_u (.mclk_i, .reset_i, .reg_wr_i, .reg_rd_i, .reg_ack_o,
  .acc_start_i, .busy_o, .mem_addr_phase_o, .mem_data_ready_o, .mem_last_o, .mem_recovery_o, .reg_rdata_o);

// ==== tb/tb_top.sv ====
// register and access sequences for the bank wait-state timing block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic        acc_start_i = 1'b0, acc_bank_i = 1'b0, acc_write_i = 1'b0;
  logic [15:0] reg_addr_i = 16'h0000;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic [3:0]  acc_beats_i = 4'h2;
  wire  [31:0] reg_rdata_o;
  wire         reg_ack_o, mem_addr_phase_o, mem_data_ready_o, mem_last_o, mem_recovery_o, busy_o;
  wire  [7:0]  gap, beat, rec;
  int          n_errors = 0, n_compared = 0;
  logic [15:0] ofs [4] = '{16'h1508, 16'h150C, 16'h1514, 16'h1518};
  logic [2:0]  fa [4] = '{3'h0, 3'h7, 3'h3, 3'h5};
  logic [2:0]  fd [4] = '{3'h7, 3'h0, 3'h2, 3'h6};
  logic [2:0]  fr [4] = '{3'h1, 3'h6, 3'h0, 3'h7};
  always #10 mclk_i = ~mclk_i;
  bank_wait_state_timing dut_u (.mclk_i, .reset_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .reg_ack_o, .acc_start_i, .acc_bank_i, .acc_write_i, .acc_beats_i,
    .mem_addr_phase_o, .mem_data_ready_o, .mem_last_o, .mem_recovery_o, .busy_o);
  mem_dev mem_u (.mclk_i, .addr_i(mem_addr_phase_o), .data_i(mem_data_ready_o), .rec_i(mem_recovery_o),
    .gap_o(gap), .beat_o(beat), .rec_o(rec));
  task give_verdict;
    $display("errors %0d of %0d compared", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk_reg(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task chk_cnt(input string nm, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s exp %0d got %0d", nm, e, g);
    end
  endtask
  task reg_op(input logic wr, input logic [15:0] a, input logic [31:0] d, e);
    @(posedge mclk_i);
    reg_wr_i <= wr;
    reg_rd_i <= !wr;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1 chk_reg("reg_ack_o", 32'h0000_0001, {31'h0, reg_ack_o});
    if (!wr) chk_reg("reg_rdata_o", e, reg_rdata_o);
  endtask
  // beats fixed at two so both the first-data and beat-to-beat gaps show
  task acc(input logic [1:0] k, input logic [2:0] a, d, r);
    @(posedge mclk_i);
    acc_start_i <= 1'b1;
    acc_bank_i <= k[1];
    acc_write_i <= k[0];
    @(posedge mclk_i);
    acc_start_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    for (int i = 0; i < 40 && busy_o !== 1'b0; i++) begin
      @(posedge mclk_i);
      #1;
    end
    if (busy_o !== 1'b0) begin
      n_errors++;
      give_verdict;
    end
    // strobe to strobe is the programmed waits plus one; recovery is one base cycle plus the extra
    chk_cnt("gap", {5'h0, a} + 8'h01, gap);
    chk_cnt("beat", {5'h0, d} + 8'h01, beat);
    chk_cnt("rec", {5'h0, r} + 8'h01, rec);
  endtask
  initial begin
    repeat (5) @(posedge mclk_i);
    reset_i <= 1'b0;
    for (int k = 0; k < 4; k++) reg_op(1'b0, ofs[k], 32'h0, 32'h0007_0707);
    acc(2'h3, 3'h7, 3'h7, 3'h7);
    for (int k = 0; k < 4; k++) reg_op(1'b1, ofs[k], {13'h1FFF, fa[k], 5'h1F, fd[k], 5'h1F, fr[k]}, 32'h0);
    reg_op(1'b1, 16'h1510, 32'hFFFF_FFFF, 32'h0);
    reg_op(1'b0, 16'h1510, 32'h0, 32'h0);
    for (int k = 0; k < 4; k++) begin
      reg_op(1'b0, ofs[k], 32'h0, {13'h0, fa[k], 5'h0, fd[k], 5'h0, fr[k]});
      acc(k[1:0], fa[k], fd[k], fr[k]);
    end
    @(posedge mclk_i);
    reset_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    reset_i <= 1'b0;
    for (int k = 0; k < 4; k++) reg_op(1'b0, ofs[k], 32'h0, 32'h0007_0707);
    acc(2'h0, 3'h7, 3'h7, 3'h7);
    give_verdict;
  end
endmodule // tb_top
